/* common/sie_pkg.sv */
// types for the skip and immediate execution block
package sie_pkg;
  typedef logic [15:0] sie_word_t;
  typedef enum logic [2:0] {
    cond_equal = 3'h0,
    cond_sign_clear = 3'h1,
    cond_signed_ge_ovf = 3'h2,
    cond_unsigned_ge = 3'h3,
    cond_not_equal = 3'h4,
    cond_sign_set = 3'h5,
    cond_signed_lt_ovf = 3'h6,
    cond_unsigned_lt = 3'h7
  } sie_cond_e;
  typedef enum logic [1:0] {
    sie_tgt_b = 2'h0,
    sie_tgt_a = 2'h1,
    sie_tgt_t = 2'h2,
    sie_tgt_x = 2'h3
  } sie_tgt_e;
  typedef enum logic [1:0] {
    sie_st_idle = 2'h0,
    sie_st_done = 2'h1
  } sie_state_e;
endpackage

/* common/sie_regs.svh */
// constants for the skip and immediate execution block
`ifndef SIE_REGS_SVH
`define SIE_REGS_SVH
`define SIE_SKP_OPCODE 5'h18
`define SIE_IMM_OPCODE 5'h1e
`define SIE_OPC_MSB 15
`define SIE_OPC_LSB 11
`define SIE_COND_MSB 10
`define SIE_COND_LSB 8
`define SIE_SR_MSB 5
`define SIE_SR_LSB 3
`define SIE_DR_MSB 2
`define SIE_DR_LSB 0
`define SIE_FUNC_OP_BIT 10
`define SIE_FUNC_REG_MSB 9
`define SIE_FUNC_REG_LSB 8
`define SIE_IMM_MSB 7
`define SIE_REG_P 3'h2
`define SIE_RESET_WORD 16'h0000
`endif

/* rtl/sie_cond_eval.sv */
// subtract-and-compare unit producing the four flags and the condition result
module sie_cond_eval
  import sie_pkg::*;
(
  input wire logic [15:0] dst_val,
  input wire logic [15:0] src_val,
  input wire sie_pkg::sie_cond_e cond,
  output logic flag_s,
  output logic flag_z,
  output logic flag_c,
  output logic flag_o,
  output logic cond_true
);
  logic [16:0] diff;
  always_comb begin
    diff = {1'b0, dst_val} + {1'b0, ~src_val} + 17'h00001;
    flag_s = diff[15];
    flag_z = (diff[15:0] == 16'h0000);
    // carry set means no borrow, dr >= sr unsigned
    flag_c = diff[16];
    flag_o = (dst_val[15] != src_val[15]) && (diff[15] != dst_val[15]);
    case (cond)
      cond_equal: cond_true = flag_z;
      cond_not_equal: cond_true = !flag_z;
      cond_sign_clear: cond_true = !flag_s;
      cond_sign_set: cond_true = flag_s;
      cond_signed_ge_ovf: cond_true = !(flag_s ^ flag_o);
      cond_signed_lt_ovf: cond_true = flag_s ^ flag_o;
      cond_unsigned_ge: cond_true = flag_c;
      cond_unsigned_lt: cond_true = !flag_c;
      default: cond_true = 1'b0;
    endcase
  end
endmodule

/* rtl/sie_exec.sv */
// execution logic for the conditional skip and immediate-argument groups
// Summary of operation
// - skip only when bits 7,6 are zero; cond 10:8, source 5:3, dest 2:0.
// - skip opcode with bits 7,6 not both zero goes to extended group.
// - true condition skips the next instruction, false continues normally.
// - program counter operand reads as the address after the skip.
// - compare computes dest minus source giving sign, zero, carry, overflow.
// - code 000 true on zero set, code 100 true on zero clear.
// - code 001 true on sign clear, code 101 on sign set.
// - code 010 true on sign xor overflow clear, 110 when set.
// - code 011 true on carry set, 111 on carry clear; unsigned.
// - immediate group: bits 10:8 function, bits 7:0 signed immediate.
// - immediate widened to 16 bits by copying bit 7 upward.
// - function bits 9,8 pick B, A, T, X; bit 10 picks add.
// - load opcodes 170000 B, 170400 A, 171000 T.
// - 171400 loads X; 172000 and 172400 add to B and A.
// - 173000 and 173400 add to T and X.
// - load writes all sixteen extended bits into the register.
// - add writes register plus extended immediate back.
// - add updates carry and overflow like the memory add.
module sie_exec
  import sie_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] pc_next,
  input wire logic [15:0] src_reg_val,
  input wire logic [15:0] dst_reg_val,
  input wire logic [15:0] tgt_reg_val,
  output logic [2:0] src_sel,
  output logic [2:0] dst_sel,
  output logic [1:0] tgt_sel,
  output logic done,
  output logic skip_next,
  output logic ext_route,
  output logic wr_en,
  output logic [1:0] wr_sel,
  output logic [15:0] wr_data,
  output logic flags_wr,
  output logic carry_out,
  output logic ovf_out,
  output logic flag_s_out,
  output logic flag_z_out
);
  `include "sie_regs.svh"

  logic is_skp_op;
  logic is_skip;
  logic is_imm;
  logic [15:0] imm_ext;
  logic [15:0] cmp_dst;
  logic [15:0] cmp_src;
  logic [16:0] add_sum;
  logic fs;
  logic fz;
  logic fc;
  logic fo;
  logic ctrue;
  sie_cond_e cond;
  logic [15:0] chk_diff;

  logic done_reg, done_next;
  logic skip_reg, skip_next_v;
  logic ext_reg, ext_next;
  logic wr_en_reg, wr_en_next;
  logic [1:0] wr_sel_reg, wr_sel_next;
  logic [15:0] wr_data_reg, wr_data_next;
  logic flags_wr_reg, flags_wr_next;
  logic carry_reg, carry_next;
  logic ovf_reg, ovf_next;
  logic fs_reg, fs_next;
  logic fz_reg, fz_next;

  // register file read selects are combinational from the instruction word
  assign src_sel = instr[`SIE_SR_MSB:`SIE_SR_LSB];
  assign dst_sel = instr[`SIE_DR_MSB:`SIE_DR_LSB];
  assign tgt_sel = instr[`SIE_FUNC_REG_MSB:`SIE_FUNC_REG_LSB];
  assign cond = sie_cond_e'(instr[`SIE_COND_MSB:`SIE_COND_LSB]);

  always_comb begin
    is_skp_op = (instr[`SIE_OPC_MSB:`SIE_OPC_LSB] == `SIE_SKP_OPCODE);
    is_skip = is_skp_op && (instr[7:6] == 2'h0);
    is_imm = (instr[`SIE_OPC_MSB:`SIE_OPC_LSB] == `SIE_IMM_OPCODE);
    imm_ext = {{8{instr[`SIE_IMM_MSB]}}, instr[7:0]};
    cmp_dst = (dst_sel == `SIE_REG_P) ? pc_next : dst_reg_val;
    cmp_src = (src_sel == `SIE_REG_P) ? pc_next : src_reg_val;
    add_sum = {1'b0, tgt_reg_val} + {1'b0, imm_ext};
  end

  sie_cond_eval u_cond (
    .dst_val(cmp_dst),
    .src_val(cmp_src),
    .cond(cond),
    .flag_s(fs),
    .flag_z(fz),
    .flag_c(fc),
    .flag_o(fo),
    .cond_true(ctrue)
  );

  always_comb begin
    done_next = 1'b0;
    skip_next_v = 1'b0;
    ext_next = 1'b0;
    wr_en_next = 1'b0;
    wr_sel_next = wr_sel_reg;
    wr_data_next = wr_data_reg;
    flags_wr_next = 1'b0;
    carry_next = carry_reg;
    ovf_next = ovf_reg;
    fs_next = fs_reg;
    fz_next = fz_reg;
    if (instr_valid) begin
      if (is_skip) begin
        done_next = 1'b1;
        skip_next_v = ctrue;
        wr_en_next = 1'b0;
        fs_next = fs;
        fz_next = fz;
        carry_next = fc;
        ovf_next = fo;
      end else if (is_skp_op) begin
        ext_next = 1'b1;
      end else if (is_imm) begin
        done_next = 1'b1;
        wr_en_next = 1'b1;
        wr_sel_next = instr[`SIE_FUNC_REG_MSB:`SIE_FUNC_REG_LSB];
        if (instr[`SIE_FUNC_OP_BIT]) begin
          wr_data_next = add_sum[15:0];
          flags_wr_next = 1'b1;
          carry_next = add_sum[16];
          ovf_next = (tgt_reg_val[15] == imm_ext[15]) && (add_sum[15] != tgt_reg_val[15]);
        end else begin
          wr_data_next = imm_ext;
          flags_wr_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_reg <= 1'b0;
      skip_reg <= 1'b0;
      ext_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_sel_reg <= 2'h0;
      wr_data_reg <= `SIE_RESET_WORD;
      flags_wr_reg <= 1'b0;
      carry_reg <= 1'b0;
      ovf_reg <= 1'b0;
      fs_reg <= 1'b0;
      fz_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      skip_reg <= skip_next_v;
      ext_reg <= ext_next;
      wr_en_reg <= wr_en_next;
      wr_sel_reg <= wr_sel_next;
      wr_data_reg <= wr_data_next;
      flags_wr_reg <= flags_wr_next;
      carry_reg <= carry_next;
      ovf_reg <= ovf_next;
      fs_reg <= fs_next;
      fz_reg <= fz_next;
    end
  end

  assign done = done_reg;
  assign skip_next = skip_reg;
  assign ext_route = ext_reg;
  assign wr_en = wr_en_reg;
  assign wr_sel = wr_sel_reg;
  assign wr_data = wr_data_reg;
  assign flags_wr = flags_wr_reg;
  assign carry_out = carry_reg;
  assign ovf_out = ovf_reg;
  assign flag_s_out = fs_reg;
  assign flag_z_out = fz_reg;

  // checks: one cycle latency from an accepted word to its result
  AST_SKIP_DECODE: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skp_op && instr[7:6] != 2'h0 |=> !done && ext_route)
    else $error("skip with bits 7,6 set not routed to extended group");
  AST_EXT_ROUTE: assert property (@(posedge clk) disable iff (reset)
    ext_route |-> $past(instr_valid) && $past(instr[7:6]) != 2'h0)
    else $error("extended route without extended word");
  AST_SKIP_EQ: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_equal && cmp_dst == cmp_src |=> skip_next)
    else $error("equal skip not taken");
  AST_SKIP_UNS: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_unsigned_lt |=> skip_next == ($past(cmp_dst) < $past(cmp_src)))
    else $error("unsigned less-than wrong");
  AST_SKIP_SGN: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_signed_ge_ovf
    |=> skip_next == ($signed($past(cmp_dst)) >= $signed($past(cmp_src))))
    else $error("signed ge with overflow wrong");
  AST_SKIP_NOWR: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip |=> !wr_en && !flags_wr)
    else $error("skip wrote a register");
  AST_LOAD_DATA: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_imm && !instr[10] |=> wr_en && !flags_wr
    && wr_data == {{8{$past(instr[7])}}, $past(instr[7:0])})
    else $error("load immediate data wrong");
  AST_ADD_DATA: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_imm && instr[10] |=> wr_en && flags_wr
    && wr_data == $past(tgt_reg_val) + {{8{$past(instr[7])}}, $past(instr[7:0])})
    else $error("add immediate sum wrong");
  AST_TGT_SEL: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_imm |=> wr_sel == $past(instr[9:8]))
    else $error("immediate target wrong");
  // second subtractor so the flag checks do not lean on the unit they judge
  assign chk_diff = cmp_dst - cmp_src;
  AST_SKIP_NEQ: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_not_equal
    |=> skip_next == ($past(cmp_dst) != $past(cmp_src)))
    else $error("unequal skip wrong");
  AST_SKIP_SCLR: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_sign_clear |=> skip_next == !$past(chk_diff[15]))
    else $error("sign clear skip wrong");
  AST_SKIP_SSET: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_sign_set |=> skip_next == $past(chk_diff[15]))
    else $error("sign set skip wrong");
  AST_SKIP_SLT: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_signed_lt_ovf
    |=> skip_next == ($signed($past(cmp_dst)) < $signed($past(cmp_src))))
    else $error("signed less-than with overflow wrong");
  AST_SKIP_UGE: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && cond == cond_unsigned_ge
    |=> skip_next == ($past(cmp_dst) >= $past(cmp_src)))
    else $error("unsigned greater-or-equal wrong");
  AST_SKIP_FLAGS: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip |=> flag_z_out == ($past(chk_diff) == 16'h0000)
    && flag_s_out == $past(chk_diff[15])
    && carry_out == ($past(cmp_dst) >= $past(cmp_src)))
    else $error("compare sign, zero or carry wrong");
  AST_SKIP_OVF: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip |=> ovf_out == (($past(cmp_dst[15]) != $past(cmp_src[15]))
    && ($past(chk_diff[15]) != $past(cmp_dst[15]))))
    else $error("compare overflow wrong");
  AST_PC_DST: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && dst_sel == `SIE_REG_P |-> cmp_dst == pc_next)
    else $error("pc destination operand not the next address");
  AST_PC_SRC: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && src_sel == `SIE_REG_P |-> cmp_src == pc_next)
    else $error("pc source operand not the next address");
  AST_SKIP_DONE: assert property (@(posedge clk) disable iff (reset)
    skip_next |-> done)
    else $error("skip pulse without a finished skip word");
  AST_SKIP_ONE: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip |=> done && !ext_route)
    else $error("skip word not finished in one cycle");
  AST_OTHER_OPC: assert property (@(posedge clk) disable iff (reset)
    instr_valid && !is_skp_op && !is_imm |=> !done && !wr_en && !ext_route && !flags_wr)
    else $error("foreign opcode produced a result");
  AST_EXT_QUIET: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skp_op && !is_skip |=> !wr_en && !skip_next && !flags_wr)
    else $error("extended word acted as a skip");
  AST_IMM_NOSKIP: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_imm |=> done && !skip_next && !ext_route)
    else $error("immediate word decoded wrongly");
  AST_ADD_CARRY: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_imm && instr[10] |=> carry_out == (({1'b0, $past(tgt_reg_val)}
    + {1'b0, {8{$past(instr[7])}}, $past(instr[7:0])}) > 17'h0ffff))
    else $error("add immediate carry wrong");
  AST_ADD_OVF: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_imm && instr[10] |=> ovf_out == (($past(tgt_reg_val[15]) == $past(instr[7]))
    && (wr_data[15] != $past(tgt_reg_val[15]))))
    else $error("add immediate overflow wrong");
  AST_LOAD_FLAGS: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_imm && !instr[10] |=> $stable(carry_out) && $stable(ovf_out))
    else $error("load immediate touched carry or overflow");
  AST_SKIP_KEEP: assert property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip |=> $stable(wr_data) && $stable(wr_sel))
    else $error("skip changed the write path");
  AST_WR_PULSE: assert property (@(posedge clk) disable iff (reset)
    wr_en |-> done)
    else $error("register write without a finished word");
  AST_FLAGS_ADD_ONLY: assert property (@(posedge clk) disable iff (reset)
    flags_wr |-> wr_en && done)
    else $error("status update without an add");
  COV_SKIP_TAKEN: cover property (@(posedge clk) disable iff (reset) skip_next);
  COV_ADD_CARRY: cover property (@(posedge clk) disable iff (reset) flags_wr && carry_out);
  COV_EXT: cover property (@(posedge clk) disable iff (reset) ext_route);
  COV_LOAD_KEEP: cover property (@(posedge clk) disable iff (reset) wr_en && !flags_wr && carry_out);
  COV_SKIP_PC: cover property (@(posedge clk) disable iff (reset)
    instr_valid && is_skip && src_sel == `SIE_REG_P);
endmodule

/* verif/sie_rf_model.sv */
// register file model facing the skip and immediate execution block
module sie_rf_model (
  input wire logic clk,
  input wire logic [2:0] src_sel,
  input wire logic [2:0] dst_sel,
  input wire logic [1:0] tgt_sel,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [15:0] wr_data,
  output logic [15:0] src_reg_val,
  output logic [15:0] dst_reg_val,
  output logic [15:0] tgt_reg_val
);
  timeunit 1ns;
  timeprecision 1ns;
  // compare operands, seeded by the bench; slot 2 holds junk so a missed pc pick shows
  logic [15:0] gr [8];
  // write targets b, a, t, x
  logic [15:0] tr [4];
  // combinational reads, as the block expects
  assign src_reg_val = gr[src_sel];
  assign dst_reg_val = gr[dst_sel];
  assign tgt_reg_val = tr[tgt_sel];
  // plain always: the bench also seeds these arrays
  always @(posedge clk) begin
    if (wr_en) begin
      tr[wr_sel] <= wr_data;
    end
  end
endmodule

/* verif/test_skip_and_immediate_exec.sv */
// self-checking bench for the skip and immediate execution block
module test_skip_and_immediate_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [15:0] pc_next = 16'h0000;
  logic [15:0] src_reg_val, dst_reg_val, tgt_reg_val, wr_data;
  logic [2:0] src_sel, dst_sel;
  logic [1:0] tgt_sel, wr_sel;
  logic done, skip_next, ext_route, wr_en, flags_wr, carry_out, ovf_out, flag_s_out, flag_z_out;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] dv [4] = '{16'h0005, 16'h7fff, 16'h0001, 16'h8000};
  logic [15:0] sv [4] = '{16'h0005, 16'hffff, 16'h0002, 16'h0001};

  sie_exec uut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .pc_next(pc_next), .src_reg_val(src_reg_val), .dst_reg_val(dst_reg_val),
    .tgt_reg_val(tgt_reg_val), .src_sel(src_sel), .dst_sel(dst_sel), .tgt_sel(tgt_sel),
    .done(done), .skip_next(skip_next), .ext_route(ext_route), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .flags_wr(flags_wr), .carry_out(carry_out),
    .ovf_out(ovf_out), .flag_s_out(flag_s_out), .flag_z_out(flag_z_out));
  sie_rf_model rf (.clk(clk), .src_sel(src_sel), .dst_sel(dst_sel), .tgt_sel(tgt_sel),
    .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .src_reg_val(src_reg_val),
    .dst_reg_val(dst_reg_val), .tgt_reg_val(tgt_reg_val));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one word, one cycle of valid; outputs settle just after the answer edge
  task automatic go(input logic [15:0] w);
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic skip_conds();
    logic [15:0] d, s, df;
    logic z, c, o, n, e;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 8; k++) begin
        d = dv[p];
        s = sv[p];
        df = d - s;
        n = df[15];
        z = (df == 16'h0000);
        c = (d >= s);
        o = (d[15] != s[15]) && (df[15] != d[15]);
        case (k[1:0])
          2'h0: e = z;
          2'h1: e = !n;
          2'h2: e = !(n ^ o);
          default: e = c;
        endcase
        if (k[2]) e = !e;
        rf.gr[3] = s;
        rf.gr[5] = d;
        go({5'h18, k[2:0], 2'b00, 3'h3, 3'h5});
        chk({src_sel, dst_sel}, 16'o35);
        chk(done, 1'b1);
        chk(skip_next, e);
        chk({flag_s_out, flag_z_out, carry_out, ovf_out}, {n, z, c, o});
        chk({wr_en, flags_wr, ext_route}, 3'h0);
      end
    end
  endtask

  task automatic skip_pc();
    rf.gr[2] = 16'hedcb;
    pc_next = 16'h1234;
    rf.gr[5] = 16'h1234;
    go({5'h18, 3'h0, 2'b00, 3'h2, 3'h5});
    chk(skip_next, 1'b1);
    rf.gr[3] = 16'h1234;
    go({5'h18, 3'h0, 2'b00, 3'h3, 3'h2});
    chk(skip_next, 1'b1);
  endtask

  task automatic ext_and_refused();
    for (int b = 1; b < 4; b++) begin
      go({5'h18, 3'h0, b[1:0], 6'o35});
      chk({ext_route, skip_next, wr_en}, 3'h4);
    end
    go(16'hf800);
    chk({done, ext_route, wr_en, flags_wr}, 4'h0);
  endtask

  // adds first, from saturating seeds, so carry and overflow both show
  task automatic imm_ops();
    logic [15:0] old, x, ex;
    logic [16:0] sm;
    logic [1:0] kept;
    for (int k = 15; k >= 0; k--) begin
      x = k[0] ? 16'h007f : 16'hff80;
      @(posedge clk);
      #1;
      old = rf.tr[k[2:1]];
      kept = {carry_out, ovf_out};
      sm = {1'b0, old} + {1'b0, x};
      ex = k[3] ? sm[15:0] : x;
      go({5'h1e, k[3:1], x[7:0]});
      chk(tgt_sel, k[2:1]);
      chk({done, wr_en, wr_sel}, {2'b11, k[2:1]});
      chk(wr_data, ex);
      chk(flags_wr, k[3]);
      if (k[3]) begin
        chk({carry_out, ovf_out}, {sm[16], (old[15] == x[15]) && (sm[15] != old[15])});
      end else begin
        chk({carry_out, ovf_out}, kept);
      end
    end
  endtask

  initial begin
    foreach (rf.gr[i]) rf.gr[i] = 16'h0000;
    rf.tr = '{16'h7fff, 16'h8000, 16'hffff, 16'h0001};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk({done, wr_en, flags_wr, ext_route}, 4'h0);
    skip_conds();
    skip_pc();
    ext_and_refused();
    imm_ops();
    close_out();
  end
endmodule
